// File: verification/pmc_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// Host model: register master and chip select
module pmc_host_model (
  // Clock
  input  wire       clk,
  // Register master
  output reg        cs_n,
  output reg        reg_wr,
  output reg        reg_rd,
  output reg  [5:0] reg_addr,
  output reg  [7:0] reg_wdata,
  input  wire [7:0] reg_rdata,
  input  wire       reg_rvalid
);
  initial begin
    cs_n = 1'b1; // Always driven, never left floating
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
  end
  // Read data during a write is simply not looked at
  task automatic wr(input [5:0] a, input [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input [5:0] a, output [7:0] d, output ok);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    ok = reg_rvalid;
    d = reg_rdata;
  endtask
  // Low selects the port for framed transfers
  task automatic sel(input v);
    @(negedge clk);
    cs_n = v;
  endtask
endmodule // pmc_host_model

// File: verification/pmc_power_mode_assertions.sv
`timescale 1ns/1ps
// ==========================================================
// Checker on the power mode ports
module pmc_power_mode_assertions (
  // Clock and reset
  input wire       clk,
  input wire       arst_n,
  // Host side
  input wire       cs_n,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [5:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_rvalid,
  // Mode status
  input wire       mode_standby,
  input wire       mode_measure,
  input wire       mode_sleep,
  input wire       sensing_en,
  input wire       low_power,
  input wire [3:0] eff_rate,
  input wire       sample_tick,
  input wire       fifo_flush,
  input wire       i2c_sel,
  input wire       spi_sel
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // A later write could undo the mode, so only lone writes are judged
  wire ctl_wr = reg_wr && reg_addr == 6'h2d;
  chk_standby_quiet: assert property (mode_standby |-> !sensing_en && !sample_tick)
    else $error("sensing active in standby");
  chk_measure_go: assert property (ctl_wr && reg_wdata[5:3] == 3'b001 ##1 !ctl_wr
    |=> mode_measure && sensing_en) else $error("measure not entered");
  chk_standby_go: assert property (ctl_wr && !reg_wdata[3] ##1 !ctl_wr |=> mode_standby)
    else $error("standby not entered");
  chk_one_mode: assert property ($onehot({mode_standby, mode_measure, mode_sleep}))
    else $error("mode not one-hot");
  chk_sleep_rate: assert property (mode_sleep |-> eff_rate == 4'h6)
    else $error("sleep rate wrong");
  chk_low_power: assert property (low_power |-> !mode_standby)
    else $error("low power in standby");
  chk_fifo_kept: assert property (mode_standby |-> !fifo_flush)
    else $error("fifo flushed");
  chk_read_answer: assert property (reg_rd && !reg_wr |=> reg_rvalid)
    else $error("read not answered");
  chk_no_initiate: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("unrequested answer");
  chk_i2c_mode: assert property (cs_n [*4] |-> i2c_sel && !spi_sel)
    else $error("i2c not selected");
  chk_spi_mode: assert property (!cs_n [*4] |-> spi_sel && !i2c_sel)
    else $error("spi not selected");
  cov_measure: cover property ($rose(mode_measure));
  cov_sleep: cover property ($rose(mode_sleep));
  cov_spi: cover property ($rose(spi_sel));
endmodule // pmc_power_mode_assertions
bind pmc_power_mode pmc_power_mode_assertions u_chk (
  .clk          (clk),
  .arst_n       (arst_n),
  .cs_n         (cs_n),
  .reg_wr       (reg_wr),
  .reg_rd       (reg_rd),
  .reg_addr     (reg_addr),
  .reg_wdata    (reg_wdata),
  .reg_rvalid   (reg_rvalid),
  .mode_standby (mode_standby),
  .mode_measure (mode_measure),
  .mode_sleep   (mode_sleep),
  .sensing_en   (sensing_en),
  .low_power    (low_power),
  .eff_rate     (eff_rate),
  .sample_tick  (sample_tick),
  .fifo_flush   (fifo_flush),
  .i2c_sel      (i2c_sel),
  .spi_sel      (spi_sel)
);

// File: verification/power_mode_control_tb_top.sv
`timescale 1ns/1ps
// ==========================================================
// Bench top
module power_mode_control_tb_top;
  localparam int DIV = 4;
  reg        clk = 1'b0;
  reg        arst_n = 1'b0;
  reg  [7:0] act_level = 8'h00;
  wire       cs_n, reg_wr, reg_rd, reg_rvalid, mode_standby, mode_measure, mode_sleep;
  wire       sensing_en, low_power, sample_tick, conv_tick, fifo_flush, i2c_sel, spi_sel;
  wire [5:0] reg_addr;
  wire [7:0] reg_wdata, reg_rdata;
  wire [3:0] eff_rate;
  wire [4:0] ev = {conv_tick, sample_tick, mode_sleep, mode_measure, mode_standby};
  int        mismatches = 0;
  int        checked = 0;
  int        n;
  reg  [7:0] rdat;
  reg        rok;
  always #4 clk = ~clk;
  pmc_power_mode #(.BASE_DIV(DIV)) uut (
    .clk          (clk),
    .arst_n       (arst_n),
    .cs_n         (cs_n),
    .reg_wr       (reg_wr),
    .reg_rd       (reg_rd),
    .reg_addr     (reg_addr),
    .reg_wdata    (reg_wdata),
    .reg_rdata    (reg_rdata),
    .reg_rvalid   (reg_rvalid),
    .act_level    (act_level),
    .mode_standby (mode_standby),
    .mode_measure (mode_measure),
    .mode_sleep   (mode_sleep),
    .sensing_en   (sensing_en),
    .low_power    (low_power),
    .eff_rate     (eff_rate),
    .sample_tick  (sample_tick),
    .conv_tick    (conv_tick),
    .fifo_flush   (fifo_flush),
    .i2c_sel      (i2c_sel),
    .spi_sel      (spi_sel)
  );
  pmc_host_model host (
    .clk        (clk),
    .cs_n       (cs_n),
    .reg_wr     (reg_wr),
    .reg_rd     (reg_rd),
    .reg_addr   (reg_addr),
    .reg_wdata  (reg_wdata),
    .reg_rdata  (reg_rdata),
    .reg_rvalid (reg_rvalid)
  );
  task automatic give_verdict;
    $display("counts: %0d mismatches in %0d checks", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wt(input int b, input int lim);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (ev[b] !== 1'b1 && n < lim);
    if (ev[b] !== 1'b1) begin
      mismatches++;
      $display("mismatch wait event %0d expected 1 seen %b", b, ev[b]);
      give_verdict();
    end
  endtask
  task automatic t_reset;
    logic [7:0] rv [4] = '{8'h00, 8'h00, 8'h0a, 8'h00};
    logic [5:0] ra [4] = '{6'h25, 6'h26, 6'h2c, 6'h2d};
    cmp("standby", 1, mode_standby);
    for (int i = 0; i < 4; i++) begin
      host.rd(ra[i], rdat, rok);
      cmp("rvalid", 1, rok);
      cmp("reset value", rv[i], rdat);
    end
  endtask
  task automatic t_rates;
    host.wr(6'h2d, 8'h08);
    repeat (2) @(negedge clk);
    cmp("measure", 1, mode_measure);
    for (int c = 15; c > 12; c--) begin
      host.wr(6'h2c, 8'(c));
      repeat (3) wt(3, 4000);
      cmp("tick period", (2 * DIV) << (15 - c), n);
    end
    repeat (2) wt(4, 100);
    cmp("conv period", DIV, n);
    host.wr(6'h2c, 8'h18);
    @(negedge clk);
    cmp("low power", 1, low_power);
    cmp("rate in use", 8, eff_rate);
    repeat (2) wt(4, 3000);
    cmp("conv period lp", (2 * DIV) << 7, n);
  endtask
  task automatic t_standby;
    host.wr(6'h2d, 8'h00);
    repeat (2) @(negedge clk);
    cmp("standby", 1, mode_standby);
    cmp("low power off", 0, low_power);
    n = 0;
    repeat (64) begin
      @(negedge clk);
      n += (sample_tick !== 1'b0) + (conv_tick !== 1'b0);
    end
    cmp("standby ticks", 0, n);
    cmp("fifo kept", 0, fifo_flush);
  endtask
  task automatic t_sleep;
    host.wr(6'h25, 8'h10);
    host.wr(6'h26, 8'h01);
    host.rd(6'h26, rdat, rok);
    cmp("inactivity time", 8'h01, rdat);
    host.wr(6'h2d, 8'h38);
    wt(2, 40000);
    cmp("sleep rate", 6, eff_rate);
    act_level = 8'hff;
    wt(1, 10000);
    cmp("woken", 0, mode_sleep);
  endtask
  task automatic t_cs;
    host.sel(1'b0);
    repeat (5) @(negedge clk);
    cmp("spi mode", 1, spi_sel);
    cmp("i2c off", 0, i2c_sel);
    host.sel(1'b1);
    repeat (5) @(negedge clk);
    cmp("i2c mode", 1, i2c_sel);
  endtask
  initial begin
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    t_reset();
    t_rates();
    t_standby();
    t_sleep();
    t_cs();
    // Second reset in mid-run must bring back standby and the reset values
    @(negedge clk);
    arst_n = 1'b0;
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    t_reset();
    give_verdict();
  end
endmodule // power_mode_control_tb_top

// File: verilog/pmc_consts.vh
`ifndef PMC_CONSTS_VH
`define PMC_CONSTS_VH
// Behaviour
// - After power-up the block rests in standby, sensing off, until measure is set.
// - Writing one to measure bit D3 of the power control register starts measuring.
// - Writing zero to the measure bit returns to standby with no measurements.
// - In standby every register can be read and written.
// - Four-bit rate code: 1111 gives 3200 Hz, each lower code halves it.
// - Bit 4 of the rate register selects low power, lowering internal sampling.
// - Auto sleep needs thresholds programmed, then auto-sleep D4 and link D5 set.
// - While auto-sleeping the block samples below 12.5 Hz.
// - Entering standby leaves the FIFO contents intact.
// - The block only answers register accesses and never initiates transfers.
// - Chip select held high selects the serial port's I2C mode.

// ==========================================================
// Register offsets
`define PMC_ADDR_W          6
`define PMC_OFS_INACT_THR   6'h25
`define PMC_OFS_INACT_TIME  6'h26
`define PMC_OFS_RATE_PWR    6'h2c
`define PMC_OFS_SLEEP_MEAS  6'h2d

// ==========================================================
// Field positions
`define PMC_BIT_MEASURE     3
`define PMC_BIT_AUTO_SLEEP  4
`define PMC_BIT_LINK        5
`define PMC_BIT_LOW_POWER   4
`define PMC_RATE_MSB        3

// ==========================================================
// Reset values
`define PMC_RST_INACT_THR   8'h00
`define PMC_RST_INACT_TIME  8'h00
`define PMC_RST_RATE_PWR    8'h0a
`define PMC_RST_SLEEP_MEAS  8'h00

// ==========================================================
// Rates and timing
`define PMC_RATE_TOP        4'hf
`define PMC_RATE_SLEEP      4'h6
`define PMC_CLK_HZ          125000000
`define PMC_BASE_HZ         6400
`define PMC_BASE_PER_SEC    13'h1900
`endif

// File: verilog/pmc_power_mode.v
`timescale 1ns/1ps
`include "pmc_consts.vh"
module pmc_power_mode #(
  parameter BASE_DIV = `PMC_CLK_HZ / `PMC_BASE_HZ
) (
  // Clock and reset
  input  wire       clk,
  input  wire       arst_n,
  // Chip select pin
  input  wire       cs_n,
  // Register access from the serial front end
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [5:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  output reg        reg_rvalid,
  // Activity magnitude from the sensing path
  input  wire [7:0] act_level,
  // Mode status
  output wire       mode_standby,
  output wire       mode_measure,
  output wire       mode_sleep,
  output wire       sensing_en,
  output wire       low_power,
  output wire [3:0] eff_rate,
  output reg        sample_tick,
  output reg        conv_tick,
  output wire       fifo_flush,
  // Serial port selection
  output wire       i2c_sel,
  output wire       spi_sel
);

  // ========================================================
  // States
  localparam [2:0] ST_STANDBY = 3'b001;
  localparam [2:0] ST_MEASURE = 3'b010;
  localparam [2:0] ST_SLEEP   = 3'b100;

  // ========================================================
  // Functions
  function [15:0] rate_mask;
    input [3:0] code;
    reg   [16:0] span;
    begin
      // Base tick is twice the top rate; each lower code doubles the period
      // Five-bit shift count, so the slowest code still reaches the full 16-bit span
      span      = 17'h00001 << ({1'b0, `PMC_RATE_TOP} + 5'h01 - {1'b0, code});
      rate_mask = span[15:0] - 16'h0001;
    end
  endfunction

  function is_ofs;
    input [5:0] a;
    input [5:0] ofs;
    begin
      is_ofs = (a == ofs);
    end
  endfunction

  // ========================================================
  // Chip select synchroniser
  reg cs_meta_q;
  reg cs_sync_q;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cs_meta_q <= 1'b1;
      cs_sync_q <= 1'b1;
    end else begin
      cs_meta_q <= cs_n;
      cs_sync_q <= cs_meta_q;
    end
  end

  assign i2c_sel = cs_sync_q;
  assign spi_sel = ~cs_sync_q;

  // ========================================================
  // Control registers
  reg [7:0] inact_thr_q;
  reg [7:0] inact_time_q;
  reg [7:0] rate_pwr_q;
  reg [7:0] sleep_meas_q;
  wire [7:0] mem_rdata;
  reg        sel_ctl_q;
  reg [7:0]  ctl_rdata_q;
  reg [7:0]  ctl_rdata_d;

  // Registers are written in any mode, so standby configuration always works
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      inact_thr_q  <= `PMC_RST_INACT_THR;
      inact_time_q <= `PMC_RST_INACT_TIME;
      rate_pwr_q   <= `PMC_RST_RATE_PWR;
      sleep_meas_q <= `PMC_RST_SLEEP_MEAS;
    end else if (reg_wr) begin
      if (is_ofs(reg_addr, `PMC_OFS_INACT_THR)) begin
        inact_thr_q <= reg_wdata;
      end
      if (is_ofs(reg_addr, `PMC_OFS_INACT_TIME)) begin
        inact_time_q <= reg_wdata;
      end
      if (is_ofs(reg_addr, `PMC_OFS_RATE_PWR)) begin
        rate_pwr_q <= reg_wdata;
      end
      if (is_ofs(reg_addr, `PMC_OFS_SLEEP_MEAS)) begin
        sleep_meas_q <= reg_wdata;
      end
    end
  end

  pmc_regmem u_regmem (
    .clk   (clk),
    .wr_en (reg_wr),
    .addr  (reg_addr),
    .wdata (reg_wdata),
    .rdata (mem_rdata)
  );

  always @* begin
    ctl_rdata_d = 8'h00;
    case (reg_addr)
      `PMC_OFS_INACT_THR:  ctl_rdata_d = inact_thr_q;
      `PMC_OFS_INACT_TIME: ctl_rdata_d = inact_time_q;
      `PMC_OFS_RATE_PWR:   ctl_rdata_d = rate_pwr_q;
      `PMC_OFS_SLEEP_MEAS: ctl_rdata_d = sleep_meas_q;
      default:             ctl_rdata_d = 8'h00;
    endcase
  end

  // Read data only ever answers a request; nothing here starts a transfer
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_ctl_q   <= 1'b0;
      ctl_rdata_q <= 8'h00;
      reg_rvalid  <= 1'b0;
    end else begin
      sel_ctl_q   <= is_ofs(reg_addr, `PMC_OFS_INACT_THR) |
                     is_ofs(reg_addr, `PMC_OFS_INACT_TIME) |
                     is_ofs(reg_addr, `PMC_OFS_RATE_PWR) |
                     is_ofs(reg_addr, `PMC_OFS_SLEEP_MEAS);
      ctl_rdata_q <= ctl_rdata_d;
      reg_rvalid  <= reg_rd & ~reg_wr;
    end
  end

  always @* begin
    reg_rdata = sel_ctl_q ? ctl_rdata_q : mem_rdata;
  end

  // ========================================================
  // Base tick and seconds tick
  reg [15:0] base_cnt_q;
  reg        base_tick_q;
  reg [15:0] phase_q;
  reg [12:0] sec_cnt_q;
  reg        sec_tick_q;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      base_cnt_q  <= 16'h0000;
      base_tick_q <= 1'b0;
      phase_q     <= 16'h0000;
      sec_cnt_q   <= 13'h0000;
      sec_tick_q  <= 1'b0;
    end else begin
      base_tick_q <= 1'b0;
      sec_tick_q  <= 1'b0;
      if (base_cnt_q == BASE_DIV[15:0] - 16'h0001) begin
        base_cnt_q  <= 16'h0000;
        base_tick_q <= 1'b1;
        phase_q     <= phase_q + 16'h0001;
        if (sec_cnt_q == `PMC_BASE_PER_SEC - 13'h0001) begin
          sec_cnt_q  <= 13'h0000;
          sec_tick_q <= 1'b1;
        end else begin
          sec_cnt_q <= sec_cnt_q + 13'h0001;
        end
      end else begin
        base_cnt_q <= base_cnt_q + 16'h0001;
      end
    end
  end

  // ========================================================
  // Mode state machine
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [7:0] idle_sec_q;
  wire      measure_bit = sleep_meas_q[`PMC_BIT_MEASURE];
  wire      auto_on     = sleep_meas_q[`PMC_BIT_AUTO_SLEEP] & sleep_meas_q[`PMC_BIT_LINK];
  wire      active      = act_level > inact_thr_q;
  wire      inactive_long = (idle_sec_q >= inact_time_q);

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_STANDBY: begin
        if (measure_bit) begin
          state_d = ST_MEASURE;
        end
      end
      ST_MEASURE: begin
        if (!measure_bit) begin
          state_d = ST_STANDBY;
        end else if (auto_on && inactive_long) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (!measure_bit) begin
          state_d = ST_STANDBY;
        end else if (!auto_on || (sample_tick && active)) begin
          state_d = ST_MEASURE;
        end
      end
      default: state_d = ST_STANDBY;
    endcase
  end

  // Idle time counts whole seconds without activity while measuring
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q    <= ST_STANDBY;
      idle_sec_q <= 8'h00;
    end else begin
      state_q <= state_d;
      if (state_q != ST_MEASURE || (sample_tick && active)) begin
        idle_sec_q <= 8'h00;
      end else if (sec_tick_q && idle_sec_q != 8'hff) begin
        idle_sec_q <= idle_sec_q + 8'h01;
      end
    end
  end

  assign mode_standby = state_q[0];
  assign mode_measure = state_q[1];
  assign mode_sleep   = state_q[2];
  assign sensing_en   = ~state_q[0];
  // Standby never flushes; buffered samples survive a pause
  assign fifo_flush   = 1'b0;

  // ========================================================
  // Rate selection and sample ticks
  wire [3:0] cfg_rate = rate_pwr_q[`PMC_RATE_MSB:0];
  assign eff_rate  = state_q[2] ? `PMC_RATE_SLEEP : cfg_rate;
  assign low_power = rate_pwr_q[`PMC_BIT_LOW_POWER] & ~state_q[0];

  // Normal mode oversamples on every base tick; low power converts only at the data rate
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sample_tick <= 1'b0;
      conv_tick   <= 1'b0;
    end else begin
      // Gated by the next state, so no tick leaks into the first standby cycle
      sample_tick <= base_tick_q & ~state_d[0] &
                     ((phase_q & rate_mask(eff_rate)) == 16'h0000);
      conv_tick   <= base_tick_q & ~state_d[0] &
                     (~low_power | ((phase_q & rate_mask(eff_rate)) == 16'h0000));
    end
  end

endmodule // pmc_power_mode

// File: verilog/pmc_regmem.v
`timescale 1ns/1ps
// ==========================================================
// Register storage with registered read data
module pmc_regmem (
  // Clock
  input  wire       clk,
  // Access
  input  wire       wr_en,
  input  wire [5:0] addr,
  input  wire [7:0] wdata,
  output reg  [7:0] rdata
);
  reg [7:0] mem [0:63];

  // No reset on the array so it maps onto plain storage
  always @(posedge clk) begin
    if (wr_en) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule // pmc_regmem
